// [inc/rox_defs.vh]
// Constants for the four-channel relay output extension control block.
// Assumes a 250 MHz system clock and a plain strobed register port.
`ifndef ROX_DEFS_VH
`define ROX_DEFS_VH
// Register offsets (word index on the register port)
`define ROX_ADDR_EXT_TYPE 4'h0
`define ROX_ADDR_EXT_DETECT 4'h1
`define ROX_ADDR_STATUS 4'h2
`define ROX_ADDR_FORCE_SEL 4'h3
`define ROX_ADDR_FORCE_DATA 4'h4
`define ROX_ADDR_SOURCE 4'h5
`define ROX_ADDR_ON_DLY_BASE 4'h8
`define ROX_ADDR_OFF_DLY_BASE 4'hC
// Extension type codes
`define ROX_EXT_NONE 8'h00
`define ROX_EXT_RELAY 8'h05
// Source selector codes
`define ROX_SRC_OFF 1'b0
`define ROX_SRC_ON 1'b1
// Delay encoding: count of 10 per second, max 3000.0 s
`define ROX_DLY_MAX 16'h7530
`define ROX_DLY_RESET 16'h0000
// Tick of 0.1 s at 250 MHz
`define ROX_TICK_NS 32'h05F5_E100
`define ROX_CLK_NS 32'h0000_0004
`endif

// [rtl/rox_channel.v]
// One relay channel: source edge delay and force override.
// Assumes a one-cycle tick enable every 0.1 s from the top module.
`timescale 1ns/1ps
module rox_channel
(
  input wire sys_clk,
  input wire rstn,
  input wire tick,
  input wire enable,
  input wire source,
  input wire [15:0] on_delay,
  input wire [15:0] off_delay,
  input wire force_sel,
  input wire force_val,
  output reg relay_out_reg
);
  reg held_reg;
  reg src_last_reg;
  reg [15:0] count_reg;
  wire [15:0] target;
  wire settled;

  // Delay used depends on the direction of the pending change
  assign target = source ? on_delay : off_delay;
  assign settled = (count_reg >= target);

  // Counter restarts on any source change; output follows once stable
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      held_reg <= 1'b0;
      src_last_reg <= 1'b0;
      count_reg <= 16'h0000;
    end
    else
    begin
      src_last_reg <= source;
      if (source != src_last_reg)
        count_reg <= 16'h0000; // RULE_12
      else if (source != held_reg)
      begin
        if (settled)
          held_reg <= source; // RULE_09 RULE_11
        else if (tick)
          count_reg <= count_reg + 16'h0001;
      end
      else
        count_reg <= 16'h0000;
    end
  end

  // Force wins over the delayed source; disabled extension stays off
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      relay_out_reg <= 1'b0;
    else if (!enable)
      relay_out_reg <= 1'b0; // RULE_01
    else if (force_sel)
      relay_out_reg <= force_val; // RULE_05
    else
      relay_out_reg <= held_reg;
  end
endmodule // rox_channel

// [rtl/rox_relay_ctrl.v]
// Relay output extension control: registers, tick divider, four channels.
// Assumes a strobed register port on sys_clk and a module-present input.
// The relay pins come straight from flops inside the channel instances.
// What this block does
// (RULE_01) Outputs enabled only when type selects relay
// (RULE_02) Detected type field reports relay code
// (RULE_03) Status bits 0..3 show outputs on
// (RULE_04) Status word is read-only
// (RULE_05) Force select drives output from forced data
// (RULE_06) Force select bit n controls output n
// (RULE_07) Forced data bit n feeds output n
// (RULE_08) Source code 0 off, 1 on, default off
// (RULE_09) Activation delay on source rise, default zero
// (RULE_10) Delays 0..3000 s, ten counts per second
// (RULE_11) Deactivation delay on source fall, default zero
// (RULE_12) Delay counter restarts on each source change
`timescale 1ns/1ps
`include "rox_defs.vh"
module rox_relay_ctrl
#(
  parameter TICK_CYCLES = `ROX_TICK_NS / `ROX_CLK_NS
)
(
  input wire sys_clk,
  input wire rstn,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire module_present,
  output wire relay_out_a,
  output wire relay_out_b,
  output wire relay_out_c,
  output wire relay_out_d
);
  // Number of relay channels; the port list fixes it at four
  localparam NUM_CH = 4;
  // Configuration words written over the register port
  reg [7:0] ext_type_reg;
  reg [3:0] force_sel_reg;
  reg [3:0] force_data_reg;
  reg [3:0] source_reg;
  // Delay words of all channels, packed 16 bits apiece for the read mux
  wire [63:0] on_dly_vec;
  wire [63:0] off_dly_vec;
  // Shared 0.1 s divider
  reg [31:0] tick_cnt_reg;
  reg tick_reg;
  // Presence pin stages and the type they yield
  reg pres_s1_reg;
  reg pres_s2_reg;
  reg pres_s3_reg;
  reg [7:0] ext_detect_reg;
  // Internal nets
  wire [3:0] relay_vec;
  wire enable;
  wire [15:0] wdata_dly;
  reg [31:0] rdata_next;

  // Present pin from the extension connector, three-stage sampled
  // Only the second stage reads the first; a change counts once two stages agree
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pres_s1_reg <= 1'b0;
      pres_s2_reg <= 1'b0;
      pres_s3_reg <= 1'b0;
      ext_detect_reg <= `ROX_EXT_NONE;
    end
    else
    begin
      pres_s1_reg <= module_present;
      pres_s2_reg <= pres_s1_reg;
      pres_s3_reg <= pres_s2_reg;
      if (pres_s2_reg == pres_s3_reg)
        ext_detect_reg <= pres_s3_reg ? `ROX_EXT_RELAY : `ROX_EXT_NONE; // RULE_02
    end
  end

  // 0.1 s tick; a parameter so simulation can shorten it
  // One shared divider keeps every channel's delay on the same time base
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
    end
    else if (tick_cnt_reg >= TICK_CYCLES - 1)
    begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg <= 1'b1; // RULE_10
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      tick_reg <= 1'b0;
    end
  end

  // Delays of 3000.1 to 6553.5 s in bits 15:0 are clamped rather than wrapped; bits 31:16 are dropped
  // so a too-large value in bits 15:0 never turns a long delay into a short one
  assign wdata_dly = (reg_wdata[15:0] > `ROX_DLY_MAX) ? `ROX_DLY_MAX : reg_wdata[15:0]; // RULE_10
  // Force is masked too, so a disabled extension never energises a coil
  assign enable = (ext_type_reg == `ROX_EXT_RELAY); // RULE_01

  // Register writes; status has no write path at all
  // Detected type and status are read-only; writes there fall to default
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_type_reg <= `ROX_EXT_NONE;
      force_sel_reg <= 4'h0;
      force_data_reg <= 4'h0;
      source_reg <= {4{`ROX_SRC_OFF}}; // RULE_08
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ROX_ADDR_EXT_TYPE: ext_type_reg <= reg_wdata[7:0];
        `ROX_ADDR_FORCE_SEL: force_sel_reg <= reg_wdata[3:0]; // RULE_06
        `ROX_ADDR_FORCE_DATA: force_data_reg <= reg_wdata[3:0]; // RULE_07
        `ROX_ADDR_SOURCE: source_reg <= reg_wdata[3:0]; // RULE_08
        default: ;
      endcase
    end
  end

  // Per-channel delay registers and channel instances
  genvar i;
  generate
    for (i = 0; i < NUM_CH; i = i + 1)
    begin : g_ch
      reg [15:0] on_dly_reg;
      reg [15:0] off_dly_reg;
      wire hit_on;
      wire hit_off;

      // Word index match for this channel's two delay registers
      assign hit_on = reg_wr && ({28'h000_0000, reg_addr} == `ROX_ADDR_ON_DLY_BASE + i);
      assign hit_off = reg_wr && ({28'h000_0000, reg_addr} == `ROX_ADDR_OFF_DLY_BASE + i);

      // Each channel owns its delay words, so every word has a single writer
      always @(posedge sys_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          on_dly_reg <= `ROX_DLY_RESET;
          off_dly_reg <= `ROX_DLY_RESET;
        end
        else
        begin
          if (hit_on)
            on_dly_reg <= wdata_dly; // RULE_09
          if (hit_off)
            off_dly_reg <= wdata_dly; // RULE_11
        end
      end

      // Packed copies for the read mux
      assign on_dly_vec[16*i +: 16] = on_dly_reg;
      assign off_dly_vec[16*i +: 16] = off_dly_reg;

      rox_channel u_ch
      (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .tick(tick_reg),
        .enable(enable),
        .source(source_reg[i]),
        .on_delay(on_dly_reg),
        .off_delay(off_dly_reg),
        .force_sel(force_sel_reg[i]), // RULE_06
        .force_val(force_data_reg[i]), // RULE_07
        .relay_out_reg(relay_vec[i])
      );
    end
  endgenerate

  // Relay pins, each straight from a channel flop
  assign relay_out_a = relay_vec[0];
  assign relay_out_b = relay_vec[1];
  assign relay_out_c = relay_vec[2];
  assign relay_out_d = relay_vec[3];

  // Read mux; unmapped addresses read zero
  always @*
  begin
    rdata_next = 32'h0000_0000;
    case (reg_addr)
      `ROX_ADDR_EXT_TYPE: rdata_next = {24'h00_0000, ext_type_reg};
      `ROX_ADDR_EXT_DETECT: rdata_next = {24'h00_0000, ext_detect_reg}; // RULE_02
      `ROX_ADDR_STATUS: rdata_next = {28'h000_0000, relay_vec}; // RULE_03 RULE_04
      `ROX_ADDR_FORCE_SEL: rdata_next = {28'h000_0000, force_sel_reg};
      `ROX_ADDR_FORCE_DATA: rdata_next = {28'h000_0000, force_data_reg};
      `ROX_ADDR_SOURCE: rdata_next = {28'h000_0000, source_reg};
      // Activation delays, channels a to d
      `ROX_ADDR_ON_DLY_BASE: rdata_next = {16'h0000, on_dly_vec[15:0]};
      `ROX_ADDR_ON_DLY_BASE + 4'h1: rdata_next = {16'h0000, on_dly_vec[31:16]};
      `ROX_ADDR_ON_DLY_BASE + 4'h2: rdata_next = {16'h0000, on_dly_vec[47:32]};
      `ROX_ADDR_ON_DLY_BASE + 4'h3: rdata_next = {16'h0000, on_dly_vec[63:48]};
      // Deactivation delays, channels a to d
      `ROX_ADDR_OFF_DLY_BASE: rdata_next = {16'h0000, off_dly_vec[15:0]};
      `ROX_ADDR_OFF_DLY_BASE + 4'h1: rdata_next = {16'h0000, off_dly_vec[31:16]};
      `ROX_ADDR_OFF_DLY_BASE + 4'h2: rdata_next = {16'h0000, off_dly_vec[47:32]};
      `ROX_ADDR_OFF_DLY_BASE + 4'h3: rdata_next = {16'h0000, off_dly_vec[63:48]};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data stand the cycle after the strobe only
  // Zero between reads keeps a stale word off the bus
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= 32'h0000_0000;
  end
endmodule // rox_relay_ctrl

// [verif/rox_drv_model.sv]
// Relay driver stage model: coils follow the four drive lines.
// Assumes the drive lines come from flops on sys_clk.
`timescale 1ns/1ps
module rox_drv_model
(
  input wire sys_clk,
  input wire [3:0] drive,
  output reg [3:0] coil_on
);
  // One cycle of lag; a real coil is slower, only settled state is judged
  always @(posedge sys_clk)
    coil_on <= drive;
endmodule // rox_drv_model

// [verif/rox_relay_ctrl_monitor.sv]
// Checker for the relay control block, bound to its ports.
// Assumes one-cycle strobes that are never high together.
`timescale 1ns/1ps
module rox_chk
(
  input wire sys_clk,
  input wire rstn,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire module_present,
  input wire relay_out_a,
  input wire relay_out_b,
  input wire relay_out_c,
  input wire relay_out_d
);
  wire [3:0] o = {relay_out_d, relay_out_c, relay_out_b, relay_out_a};
  reg [7:0] type_reg;
  reg [3:0] fs_reg;
  reg [3:0] fd_reg;
  genvar i;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  // Shadow of the setup words, so outputs can be judged from writes
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      type_reg <= 8'h00;
      fs_reg <= 4'h0;
      fd_reg <= 4'h0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        4'h0: type_reg <= reg_wdata[7:0];
        4'h3: fs_reg <= reg_wdata[3:0];
        4'h4: fd_reg <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not idle");
  a_status_bits: assert property (s_rd(4'h2) |=> reg_rdata[3:0] == $past(o))
    else $error("status bits wrong");
  a_status_upper: assert property (s_rd(4'h2) |=> reg_rdata[31:4] == 28'h000_0000)
    else $error("status upper bits set");
  a_detect_code: assert property (s_rd(4'h1) ##0
    $past(module_present, 3) == $past(module_present, 4) |=>
    reg_rdata[7:0] == ($past(module_present, 5) ? 8'h05 : 8'h00))
    else $error("bad detect code");
  a_type_back: assert property (s_rd(4'h0) |=> reg_rdata[7:0] == $past(type_reg))
    else $error("type readback wrong");
  a_unmapped_zero: assert property (s_rd(4'h6) |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_disabled_off: assert property (type_reg != 8'h05 && $past(type_reg) != 8'h05
    |-> o == 4'h0) else $error("output on while disabled");
  for (i = 0; i < 4; i = i + 1)
  begin : g_f
    a_force_bit: assert property (type_reg == 8'h05 && $past(type_reg) == 8'h05 &&
      fs_reg[i] && $stable(fs_reg) && $stable(fd_reg) |-> o[i] == fd_reg[i])
      else $error("forced value not applied");
  end
endmodule // rox_chk
bind rox_relay_ctrl rox_chk chk (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .module_present(module_present),
  .relay_out_a(relay_out_a), .relay_out_b(relay_out_b), .relay_out_c(relay_out_c),
  .relay_out_d(relay_out_d));

// [verif/test_relay_output_extension_control.sv]
// Self-checking bench for the relay control block and a driver model.
// Assumes TICK_CYCLES cut to 4, so a delay count of 3 is 12 cycles.
`timescale 1ns/1ps
module test_relay_output_extension_control;
  reg sys_clk = 1'b0;
  reg rstn = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0000_0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg module_present = 1'b0;
  reg [31:0] seed = 32'h0000_f08c;
  wire [31:0] reg_rdata;
  wire [3:0] o;
  wire [3:0] coil;
  integer mismatches = 0;
  integer num_checks = 0;
  integer i;
  rox_relay_ctrl #(.TICK_CYCLES(4)) uut (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .module_present(module_present), .relay_out_a(o[0]),
    .relay_out_b(o[1]), .relay_out_c(o[2]), .relay_out_d(o[3]));
  rox_drv_model drv (.sys_clk(sys_clk), .drive(o), .coil_on(coil));
  initial forever #2 sys_clk = ~sys_clk;
  // Stimulus from a right-shifting Galois register, so the low bits vary
  function [31:0] lfsr(input [31:0] s);
    lfsr = s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction
  function [31:0] z(input [3:0] v);
    z = {28'h000_0000, v};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  // Outputs and coils, sampled 1 ns after the edge when settled
  task cko(input [3:0] e);
  begin
    #1 chk(z(o), z(e));
    chk(z(coil), z(e));
  end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  task wr(input [3:0] a, input [31:0] d);
  begin
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [3:0] a, input [31:0] e);
  begin
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // Hang guard: the whole run is far shorter than this
  initial
  begin
    #40000;
    mismatches = mismatches + 1;
    end_of_test;
  end
  initial
  begin
    wt(5);
    rstn <= 1'b1;
    cko(4'h0);
    rd(4'h0, 32'h0000_0000);
    rd(4'h5, 32'h0000_0000);
    rd(4'h8, 32'h0000_0000);
    rd(4'hC, 32'h0000_0000);
    wt(1);
    module_present <= 1'b1;
    wt(8);
    rd(4'h1, 32'h0000_0005);
    wt(1);
    module_present <= 1'b0;
    wt(8);
    rd(4'h1, 32'h0000_0000);
    wr(4'h5, 32'h0000_000f);
    wt(6);
    cko(4'h0);
    wr(4'h0, 32'h0000_0005);
    wr(4'h9, 32'h0001_ffff);
    rd(4'h9, 32'h0000_7530);
    wr(4'h9, 32'h0000_0000);
    for (i = 0; i < 6; i = i + 1)
    begin
      seed = lfsr(seed);
      wr(4'h5, seed);
      wt(5);
      cko(seed[3:0]);
      wr(4'h2, ~seed);
      rd(4'h2, z(seed[3:0]));
      wr(4'h3, seed >> 4);
      wr(4'h4, seed >> 8);
      wt(2);
      cko((seed[7:4] & seed[11:8]) | (~seed[7:4] & seed[3:0]));
      rd(4'h3, z(seed[7:4]));
      wr(4'h3, 32'h0000_0000);
    end
    wr(4'h5, 32'h0000_0000);
    wr(4'h8, 32'h0000_0003);
    wr(4'h5, 32'h0000_0001);
    wt(6);
    cko(4'h0);
    wt(20);
    cko(4'h1);
    wr(4'hC, 32'h0000_0003);
    wr(4'h5, 32'h0000_0000);
    wt(6);
    wr(4'h5, 32'h0000_0001);
    wr(4'h5, 32'h0000_0000);
    wt(6);
    cko(4'h1);
    wt(20);
    cko(4'h0);
    rd(4'h6, 32'h0000_0000);
    end_of_test;
  end
endmodule // test_relay_output_extension_control
